// *** afem_map.vh ***
// Register map, field positions, reset values and error codes of the axis fault monitor
`ifndef AFEM_MAP_VH
`define AFEM_MAP_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define AFEM_OFF_STATUS   8'h00
`define AFEM_OFF_MASK     8'h04
`define AFEM_OFF_CTRL     8'h08
`define AFEM_OFF_STOPCFG  8'h0c
`define AFEM_OFF_SYSCODE  8'h10
`define AFEM_OFF_AXSTATE  8'h14
`define AFEM_OFF_CODE0    8'h20
`define AFEM_CODE_SPAN    8'h10

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define AFEM_NAX          4
`define AFEM_ST_SYS_BIT   4
`define AFEM_MASK_RST     5'h00
`define AFEM_STOPCFG_RST  4'h0

// ****************************************************************
// Error codes (decimal value in comment)
// ****************************************************************
`define AFEM_E_NOTREADY   16'h03ec
`define AFEM_E_FLS        16'h044d
`define AFEM_E_RLS        16'h044e
`define AFEM_E_XSTOP      16'h044f
`define AFEM_E_SERVO      16'h0450
`define AFEM_E_POWER      16'h0451
`define AFEM_E_CHKSUM     16'h04b1
`define AFEM_E_AMP        16'h0514
`define AFEM_E_NODRV      16'h0515
`define AFEM_E_PDM        16'h0516
`define AFEM_E_SYSBASE    16'h051e
`define AFEM_E_SYSMAX     5'h10
`define AFEM_E_NONE       16'h0000
// 1101, 1102, 1103, 1104, 1105 ; 1004 ; 1201 ; 1300, 1301, 1302, 1310..1326

`endif

// *** afem_code_mem.v ***
// Per-axis last-error-code store with one write port and a registered read
module afem_code_mem (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        wr_en,
  input  wire [1:0]  wr_addr,
  input  wire [15:0] wr_data,
  input  wire [1:0]  rd_addr,
  output reg  [15:0] rd_data_q
);
  reg [15:0] mem_q [0:3];
  integer k;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (k = 0; k < 4; k = k + 1) begin
        mem_q[k] <= 16'h0000;
      end
      rd_data_q <= 16'h0000;
    end else begin
      if (wr_en) begin
        mem_q[wr_addr] <= wr_data;
      end
      rd_data_q <= mem_q[rd_addr];
    end
  end
endmodule // afem_code_mem

// *** afem_chksum.v ***
// Power-up sum check over the streamed backup data
module afem_chksum (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        bk_valid,
  input  wire        bk_last,
  input  wire [15:0] bk_word,
  input  wire [15:0] bk_expect,
  output reg         done_q,
  output reg         bad_q
);
  reg  [15:0] sum_q;
  wire [15:0] sum_d;

  assign sum_d = sum_q + bk_word;

  // Only the first stream after reset counts; later words are ignored
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sum_q  <= 16'h0000;
      done_q <= 1'b0;
      bad_q  <= 1'b0;
    end else if (bk_valid && !done_q) begin
      sum_q <= sum_d;
      if (bk_last) begin
        done_q <= 1'b1;
        bad_q  <= (sum_d != bk_expect);
      end
    end
  end
endmodule // afem_chksum

// *** afem_top.v ***
// Axis fault monitor: error detection, stop reaction, start gating and APB registers
//
// Contract
// - Positioning errors use codes 1100 to 1199
// - Forward limit off moving forward: 1101
// - Reverse limit off moving reverse: 1102
// - Codes 1101-1103 stop per stop setting
// - Servo error while moving: 1104, instant stop
// - Servo error cleared: start accepted again
// - Amplifier power lost moving: 1105, flag changes
// - Absolute system errors use codes 1200-1299
// - Power-up backup checksum mismatch: 1201, no start
// - Power-up system checks, codes 1300-1399
// - Amplifier mismatch or drive fault: 1300
// - No drive module enabled: 1301, inoperable
// - Detector module mismatch: 1302, no start
// - Config, parameter or internal fault: 1310-1326
// - Start refused while servo not ready
`include "afem_map.vh"

module afem_top (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire [3:0]  axis_start,
  input  wire [3:0]  axis_dir_fwd,
  input  wire [3:0]  axis_zero_return,
  input  wire [3:0]  axis_motion_done,
  input  wire [3:0]  forward_limit_switch,
  input  wire [3:0]  reverse_limit_switch,
  input  wire [3:0]  external_stop_flag,
  input  wire [3:0]  servo_error_flag,
  input  wire [3:0]  amp_power_ok,
  input  wire [3:0]  amp_fitted,
  input  wire [3:0]  amp_configured,
  input  wire        drive_fitted,
  input  wire        drive_enabled,
  input  wire        drive_fault,
  input  wire [3:0]  position_detector_module,
  input  wire [3:0]  pdm_configured,
  input  wire        sys_fault_valid,
  input  wire [4:0]  sys_fault_index,
  input  wire        bk_valid,
  input  wire        bk_last,
  input  wire [15:0] bk_word,
  input  wire [15:0] bk_expect,
  output reg  [3:0]  axis_run_q,
  output reg  [3:0]  decel_stop_q,
  output reg  [3:0]  quick_stop_q,
  output reg  [3:0]  servo_ready_state_flag,
  output reg         irq_q
);

  // ****************************************************************
  // Power-up check sequencer
  // ****************************************************************
  localparam [2:0] ST_CHECK = 3'b001;
  localparam [2:0] ST_RUN   = 3'b010;
  localparam [2:0] ST_LOCK  = 3'b100;

  reg  [2:0]  state_q;
  reg  [15:0] syscode_q;
  wire        chk_done;
  wire        chk_bad;
  reg  [15:0] sys_code_d;

  afem_chksum u_chk (
    .pclk      (pclk),
    .presetn   (presetn),
    .bk_valid  (bk_valid),
    .bk_last   (bk_last),
    .bk_word   (bk_word),
    .bk_expect (bk_expect),
    .done_q    (chk_done),
    .bad_q     (chk_bad)
  );

  // Most severe finding wins; an inoperable machine outranks a mismatch
  always @* begin
    sys_code_d = `AFEM_E_NONE;
    if (!drive_fitted || !drive_enabled) begin
      sys_code_d = `AFEM_E_NODRV;
    end else if ((amp_fitted != amp_configured) || drive_fault) begin
      sys_code_d = `AFEM_E_AMP;
    end else if (position_detector_module != pdm_configured) begin
      sys_code_d = `AFEM_E_PDM;
    end else if (sys_fault_valid && (sys_fault_index <= `AFEM_E_SYSMAX)) begin
      sys_code_d = `AFEM_E_SYSBASE + {11'h000, sys_fault_index};
    end else if (chk_bad) begin
      sys_code_d = `AFEM_E_CHKSUM;
    end
  end

  // Checks are evaluated once, after the backup stream ends
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q   <= ST_CHECK;
      syscode_q <= `AFEM_E_NONE;
    end else begin
      case (state_q)
        ST_CHECK: begin
          if (chk_done) begin
            syscode_q <= sys_code_d;
            state_q   <= (sys_code_d == `AFEM_E_NONE) ? ST_RUN : ST_LOCK;
          end
        end
        ST_RUN:  state_q <= ST_RUN;
        ST_LOCK: state_q <= ST_LOCK; // Only a reset leaves lock-out
        default: state_q <= ST_LOCK;
      endcase
    end
  end

  // ****************************************************************
  // APB decode and registers
  // ****************************************************************
  function is_code_addr;
    input [7:0] a;
    begin
      is_code_addr = (a >= `AFEM_OFF_CODE0) &&
                     (a < (`AFEM_OFF_CODE0 + `AFEM_CODE_SPAN)) && (a[1:0] == 2'b00);
    end
  endfunction

  reg  [4:0]  status_q;
  reg  [4:0]  mask_q;
  reg  [3:0]  stopcfg_q;
  wire        wr_acc;
  wire        rd_first;
  wire [15:0] mem_rd;
  reg  [31:0] rd_mux;
  reg         rd_hit;

  // Write lands at the edge where pready is seen high
  assign wr_acc   = psel && penable && pready && pwrite;
  assign rd_first = psel && penable && !pready;

  always @* begin
    rd_hit = 1'b1;
    rd_mux = 32'h00000000;
    case (paddr)
      `AFEM_OFF_STATUS:  rd_mux = {27'h0000000, status_q};
      `AFEM_OFF_MASK:    rd_mux = {27'h0000000, mask_q};
      `AFEM_OFF_CTRL:    rd_mux = 32'h00000000;
      `AFEM_OFF_STOPCFG: rd_mux = {28'h0000000, stopcfg_q};
      `AFEM_OFF_SYSCODE: rd_mux = {13'h0000, state_q, syscode_q};
      `AFEM_OFF_AXSTATE: rd_mux = {20'h00000, quick_stop_q, decel_stop_q, axis_run_q};
      default: begin
        if (is_code_addr(paddr)) begin
          rd_mux = {16'h0000, mem_rd};
        end else begin
          rd_hit = 1'b0;
        end
      end
    endcase
  end

  // One wait state: the code store answers a cycle after its address
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (rd_first) begin
      pready  <= 1'b1;
      prdata  <= pwrite ? 32'h00000000 : rd_mux;
      pslverr <= !rd_hit || (pwrite && (is_code_addr(paddr) ||
                 (paddr == `AFEM_OFF_SYSCODE) || (paddr == `AFEM_OFF_AXSTATE)));
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  wire [3:0] clr_cmd;
  assign clr_cmd = (wr_acc && (paddr == `AFEM_OFF_CTRL)) ? pwdata[3:0] : 4'h0;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q    <= `AFEM_MASK_RST;
      stopcfg_q <= `AFEM_STOPCFG_RST;
    end else if (wr_acc) begin
      if (paddr == `AFEM_OFF_MASK) begin
        mask_q <= pwdata[4:0];
      end
      if (paddr == `AFEM_OFF_STOPCFG) begin
        stopcfg_q <= pwdata[3:0];
      end
    end
  end

  // ****************************************************************
  // Per-axis detection and reaction
  // ****************************************************************
  wire [3:0]  err_hit;
  wire [3:0]  err_quick;
  wire [3:0]  start_refused;
  wire [15:0] err_code [0:3];
  wire        start_allowed;

  assign start_allowed = (state_q == ST_RUN);

  genvar g;
  generate
    for (g = 0; g < `AFEM_NAX; g = g + 1) begin : g_axis
      wire moving;
      wire not_ready;
      wire e_fls;
      wire e_rls;
      wire e_xst;
      wire e_srv;
      wire e_pwr;

      assign moving    = axis_run_q[g];
      assign not_ready = servo_error_flag[g] || !amp_power_ok[g];
      // Checked in every control mode, except the external stop, which counts only in zero return
      assign e_fls = moving && axis_dir_fwd[g] && !forward_limit_switch[g];
      assign e_rls = moving && !axis_dir_fwd[g] && !reverse_limit_switch[g];
      assign e_xst = moving && axis_zero_return[g] && external_stop_flag[g];
      assign e_srv = moving && servo_error_flag[g];
      assign e_pwr = moving && !amp_power_ok[g];

      assign err_quick[g]     = e_srv || e_pwr;
      assign start_refused[g] = axis_start[g] && start_allowed && !moving && not_ready;
      assign err_hit[g]       = e_fls || e_rls || e_xst || err_quick[g] || start_refused[g];
      // Codes in 1100 range while moving
      assign err_code[g] = e_srv ? `AFEM_E_SERVO :
                           e_pwr ? `AFEM_E_POWER :
                           e_fls ? `AFEM_E_FLS :
                           e_rls ? `AFEM_E_RLS :
                           e_xst ? `AFEM_E_XSTOP : `AFEM_E_NOTREADY;

      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          axis_run_q[g]             <= 1'b0;
          decel_stop_q[g]           <= 1'b0;
          quick_stop_q[g]           <= 1'b0;
          servo_ready_state_flag[g] <= 1'b1;
        end else begin
          // Flag off means ready; power loss or servo error raises it
          servo_ready_state_flag[g] <= not_ready;
          if (err_quick[g]) begin
            axis_run_q[g]   <= 1'b0;
            quick_stop_q[g] <= 1'b1;
            decel_stop_q[g] <= 1'b0;
          end else if (moving && (e_fls || e_rls || e_xst)) begin
            // Stop style follows the per-axis stop setting
            axis_run_q[g]   <= 1'b0;
            decel_stop_q[g] <= !stopcfg_q[g];
            quick_stop_q[g] <= stopcfg_q[g];
          end else if (moving && axis_motion_done[g]) begin
            axis_run_q[g] <= 1'b0;
          end else if (axis_start[g] && start_allowed && !moving && !not_ready) begin
            // Restart allowed once the servo error has gone
            axis_run_q[g]   <= 1'b1;
            decel_stop_q[g] <= 1'b0;
            quick_stop_q[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Code store write arbitration
  // ****************************************************************
  // Several axes may fault together; pending slots hold each until the
  // single write port takes it, lowest axis first.
  function [1:0] first_one;
    input [3:0] v;
    begin
      first_one = v[0] ? 2'd0 : v[1] ? 2'd1 : v[2] ? 2'd2 : 2'd3;
    end
  endfunction

  reg  [3:0]  pend_q;
  reg  [15:0] pcode_q [0:3];
  wire [1:0]  wsel;
  wire        wen;
  integer i;

  assign wsel = first_one(pend_q);
  assign wen  = |pend_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q <= 4'h0;
      for (i = 0; i < 4; i = i + 1) begin
        pcode_q[i] <= `AFEM_E_NONE;
      end
    end else begin
      for (i = 0; i < 4; i = i + 1) begin
        if (err_hit[i]) begin
          pend_q[i]  <= 1'b1;
          pcode_q[i] <= err_code[i];
        end else if (clr_cmd[i]) begin
          pend_q[i]  <= 1'b1;
          pcode_q[i] <= `AFEM_E_NONE; // Reset command clears the code
        end else if (wen && (wsel == i[1:0])) begin
          pend_q[i] <= 1'b0;
        end
      end
    end
  end

  afem_code_mem u_mem (
    .pclk      (pclk),
    .presetn   (presetn),
    .wr_en     (wen),
    .wr_addr   (wsel),
    .wr_data   (pcode_q[wsel]),
    .rd_addr   (paddr[3:2]),
    .rd_data_q (mem_rd)
  );

  // ****************************************************************
  // Interrupt status
  // ****************************************************************
  wire [4:0] ev;
  wire [4:0] w1c;
  reg        sys_ev_q;

  assign ev  = {sys_ev_q, err_hit};
  assign w1c = (wr_acc && (paddr == `AFEM_OFF_STATUS)) ? pwdata[4:0] : 5'h00;

  // Set wins over a clear in the same cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_ev_q <= 1'b0;
      status_q <= 5'h00;
      irq_q    <= 1'b0;
    end else begin
      sys_ev_q <= (state_q == ST_CHECK) && chk_done && (sys_code_d != `AFEM_E_NONE);
      status_q <= (status_q & ~w1c) | ev;
      irq_q    <= |(((status_q & ~w1c) | ev) & mask_q);
    end
  end

endmodule // afem_top

// *** afem_chk.sv ***
// Concurrent checks on the ports of the axis fault monitor
module afem_chk (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic [3:0] axis_start,
  input wire logic [3:0] axis_dir_fwd,
  input wire logic [3:0] axis_zero_return,
  input wire logic [3:0] axis_motion_done,
  input wire logic [3:0] forward_limit_switch,
  input wire logic [3:0] reverse_limit_switch,
  input wire logic [3:0] external_stop_flag,
  input wire logic [3:0] servo_error_flag,
  input wire logic [3:0] amp_power_ok,
  input wire logic [3:0] axis_run_q,
  input wire logic [3:0] decel_stop_q,
  input wire logic [3:0] quick_stop_q,
  input wire logic [3:0] servo_ready_state_flag
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Axis 0 stands for all four; the bench spreads faults over every axis
  wire ok0  = !servo_error_flag[0] && amp_power_ok[0];
  wire lim0 = axis_dir_fwd[0] ? !forward_limit_switch[0] : !reverse_limit_switch[0];
  sequence s_halt;
    !axis_run_q[0] && (decel_stop_q[0] || quick_stop_q[0]);
  endsequence
  sequence s_quick;
    !axis_run_q[0] && quick_stop_q[0];
  endsequence
  fwd_limit_a: assert property (axis_run_q[0] && axis_dir_fwd[0] && !forward_limit_switch[0]
    |=> s_halt) else $error("forward limit did not stop axis");
  rev_limit_a: assert property (axis_run_q[0] && !axis_dir_fwd[0] && !reverse_limit_switch[0]
    |=> s_halt) else $error("reverse limit did not stop axis");
  zero_stop_a: assert property (axis_run_q[0] && axis_zero_return[0] && external_stop_flag[0]
    |=> s_halt) else $error("external stop in zero return ignored");
  stop_only_zr_a: assert property (axis_run_q[0] && !axis_zero_return[0] && ok0 && !lim0
    && !axis_motion_done[0] && !axis_start[0] |=> axis_run_q[0]) else $error("axis stopped without cause");
  servo_quick_a: assert property (axis_run_q[0] && servo_error_flag[0] |=> s_quick)
    else $error("servo error did not stop at once");
  power_quick_a: assert property (axis_run_q[0] && !amp_power_ok[0] |=> s_quick)
    else $error("power loss did not stop at once");
  ready_flag_a: assert property ($past(presetn) |-> servo_ready_state_flag[0] ==
    $past(servo_error_flag[0] || !amp_power_ok[0])) else $error("servo ready flag wrong");
  start_ready_a: assert property ($rose(axis_run_q[0]) |-> !servo_ready_state_flag[0])
    else $error("axis started while not ready");
  decel_hold_a: assert property (decel_stop_q[0] && !axis_start[0] |=> decel_stop_q[0])
    else $error("decelerating stop released early");
  apb_wait_a: assert property (psel && !penable |=> !pready ##1 pready ##1 !pready)
    else $error("bus answer timing wrong");
endmodule // afem_chk

bind afem_top afem_chk i_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .axis_start(axis_start), .axis_dir_fwd(axis_dir_fwd), .axis_zero_return(axis_zero_return),
  .axis_motion_done(axis_motion_done), .forward_limit_switch(forward_limit_switch),
  .reverse_limit_switch(reverse_limit_switch), .external_stop_flag(external_stop_flag),
  .servo_error_flag(servo_error_flag), .amp_power_ok(amp_power_ok), .axis_run_q(axis_run_q),
  .decel_stop_q(decel_stop_q), .quick_stop_q(quick_stop_q),
  .servo_ready_state_flag(servo_ready_state_flag));

// *** afem_field.sv ***
// Behavioural model of the limit switches, stop inputs and servo amplifiers
module afem_field (
  input  wire logic [3:0] fls_cut,
  input  wire logic [3:0] rls_cut,
  input  wire logic [3:0] xstop,
  input  wire logic [3:0] srv_fault,
  input  wire logic [3:0] amp_absent,
  input  wire logic [3:0] cable_cut,
  output wire logic [3:0] fls_on,
  output wire logic [3:0] rls_on,
  output wire logic [3:0] xstop_on,
  output wire logic [3:0] srv_err,
  output wire logic [3:0] pwr_ok
);
  timeunit 1ns;
  timeprecision 1ns;
  // A switch reads off when its wire is cut, the same as an overrun
  assign fls_on   = ~fls_cut;
  assign rls_on   = ~rls_cut;
  assign xstop_on = xstop;
  assign srv_err  = srv_fault;
  // Missing amplifier or broken cable looks like lost power
  assign pwr_ok   = ~(amp_absent | cable_cut);
endmodule // afem_field

// *** tb.sv ***
// Self-checking bench for the axis fault monitor
`include "afem_map.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, seed = 32'h60aa, rd;
  logic [3:0]  axis_start = 0, axis_dir_fwd = 0, axis_zero_return = 0, axis_motion_done = 0;
  logic [3:0]  amp_fitted = 4'hf, amp_configured = 4'hf, position_detector_module = 4'h3;
  logic [3:0]  pdm_configured = 4'h3, fls_cut = 0, rls_cut = 0, xstop = 0, srv_fault = 0;
  logic [3:0]  amp_absent = 0, cable_cut = 0, cfg, msk;
  logic        drive_fitted = 1, drive_enabled = 1, drive_fault = 0, sys_fault_valid = 0;
  logic        bk_valid = 0, bk_last = 0, q;
  logic [4:0]  sys_fault_index = 0;
  logic [15:0] bk_word = 0, bk_expect = 0;
  logic [1:0]  n;
  wire  [31:0] prdata;
  wire         pready, pslverr, irq_q;
  wire  [3:0]  axis_run_q, decel_stop_q, quick_stop_q, servo_ready_state_flag;
  wire  [3:0]  forward_limit_switch, reverse_limit_switch, external_stop_flag;
  wire  [3:0]  servo_error_flag, amp_power_ok;
  int          num_errors = 0, total_checks = 0, cyc = 0, k;

  always #20 pclk = ~pclk;
  afem_top i_dut (.*);
  afem_field i_field (.fls_cut(fls_cut), .rls_cut(rls_cut), .xstop(xstop), .srv_fault(srv_fault),
    .amp_absent(amp_absent), .cable_cut(cable_cut), .fls_on(forward_limit_switch),
    .rls_on(reverse_limit_switch), .xstop_on(external_stop_flag), .srv_err(servo_error_flag),
    .pwr_ok(amp_power_ok));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task conclude;
    if (num_errors == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task chk(input logic [35:0] g, input logic [35:0] e);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  function logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task rnd;
    seed = lfsr(seed);
  endtask
  // Master holds the request until pready is seen at a rising edge, never
  // assumes a latency; only the cycle ceiling ends a hung wait
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk({er, rd}, {1'b0, e});
  endtask
  task start(input logic [1:0] x);
    @(posedge pclk);
    axis_start[x] <= 1'b1;
    @(posedge pclk);
    axis_start[x] <= 1'b0;
  endtask
  function logic [15:0] sys_exp(input int m, input logic [4:0] ix);
    case (m)
      1: return `AFEM_E_CHKSUM;
      2, 3: return `AFEM_E_AMP;
      4, 5: return `AFEM_E_NODRV;
      6: return `AFEM_E_PDM;
      7: return `AFEM_E_SYSBASE + {11'h0, ix};
      default: return `AFEM_E_NONE;
    endcase
  endfunction
  function logic [15:0] ax_exp(input int t);
    case (t)
      0: return `AFEM_E_FLS;
      1: return `AFEM_E_RLS;
      2: return `AFEM_E_XSTOP;
      3: return `AFEM_E_SERVO;
      4: return `AFEM_E_POWER;
      default: return `AFEM_E_NONE;
    endcase
  endfunction
  // Reset with the power-up fault chosen by m injected (none for 0), then stream the backup words
  task pwr(input int m);
    logic [15:0] w [4];
    logic [15:0] s;
    logic [15:0] c;
    s = 0;
    for (int i = 0; i < 4; i++) begin
      rnd;
      w[i] = seed[15:0];
      s = s + w[i];
    end
    rnd;
    amp_configured <= (m == 2) ? 4'h7 : 4'hf;
    {drive_fault, drive_fitted, drive_enabled} <= {m == 3, m != 4, m != 5};
    pdm_configured <= (m == 6) ? 4'h5 : 4'h3;
    sys_fault_valid <= (m == 7);
    sys_fault_index <= seed[4:0] % 17;
    bk_expect <= s + {15'h0, m == 1};
    presetn <= 1'b0;
    repeat (20) @(posedge pclk);
    chk(servo_ready_state_flag, 4'hf);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      @(posedge pclk);
      {bk_valid, bk_last, bk_word} <= {1'b1, i == 3, w[i]};
    end
    @(posedge pclk);
    {bk_valid, bk_last} <= 2'b00;
    repeat (3) @(posedge pclk);
    c = sys_exp(m, seed[4:0] % 17);
    rdc(`AFEM_OFF_SYSCODE, {13'h0, (c == 0) ? 3'b010 : 3'b100, c});
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      conclude();
    end
  end
  initial begin
    pwr(0);
    rdc(`AFEM_OFF_MASK, 32'h0);
    rdc(`AFEM_OFF_STOPCFG, 32'h0);
    rdc(`AFEM_OFF_CTRL, 32'h0);
    apb(1'b0, 8'hfc, 32'h0);
    chk({er, rd}, {1'b1, 32'h0});
    apb(1'b1, `AFEM_OFF_SYSCODE, 32'hffff);
    chk(er, 1'b1);
    for (int i = 0; i < 18; i++) begin
      k = i % 6;
      rnd;
      {msk, cfg, n} = seed[9:0];
      apb(1'b1, `AFEM_OFF_MASK, {28'h0, msk});
      apb(1'b1, `AFEM_OFF_STOPCFG, {28'h0, cfg});
      axis_dir_fwd[n] <= (k == 0) || (k != 1 && seed[11]);
      axis_zero_return[n] <= (k == 2);
      xstop[n] <= (k != 2) && seed[13];
      start(n);
      repeat (3) @(posedge pclk);
      chk(axis_run_q[n], 1'b1);
      case (k)
        0: fls_cut[n] <= 1'b1;
        1: rls_cut[n] <= 1'b1;
        2: xstop[n] <= 1'b1;
        3: srv_fault[n] <= 1'b1;
        4: if (seed[12]) amp_absent[n] <= 1'b1; else cable_cut[n] <= 1'b1;
        default: axis_motion_done[n] <= 1'b1;
      endcase
      @(posedge pclk);
      axis_motion_done <= 4'h0;
      repeat (3) @(posedge pclk);
      q = (k == 3 || k == 4) || (k < 3 && cfg[n]);
      chk({axis_run_q[n], decel_stop_q[n], quick_stop_q[n]}, {1'b0, k < 5 && !q, q});
      chk(servo_ready_state_flag[n], k == 3 || k == 4);
      repeat (6) @(posedge pclk);
      rdc(`AFEM_OFF_CODE0 + {4'h0, n, 2'b00}, ax_exp(k));
      rdc(`AFEM_OFF_STATUS, (k < 5) ? (32'h1 << n) : 32'h0);
      chk(irq_q, k < 5 && msk[n]);
      {fls_cut, rls_cut, xstop, srv_fault, amp_absent, cable_cut} <= 24'h0;
      apb(1'b1, `AFEM_OFF_STATUS, 32'h1f);
      apb(1'b1, `AFEM_OFF_CTRL, 32'h1 << n);
      rdc(`AFEM_OFF_CODE0 + {4'h0, n, 2'b00}, 32'h0);
      chk(irq_q, 1'b0);
    end
    srv_fault[n] <= 1'b1;
    repeat (2) @(posedge pclk);
    start(n);
    repeat (8) @(posedge pclk);
    chk(axis_run_q[n], 1'b0);
    rdc(`AFEM_OFF_CODE0 + {4'h0, n, 2'b00}, `AFEM_E_NOTREADY);
    srv_fault <= 4'h0;
    for (int m = 1; m < 8; m++) begin
      pwr(m);
      rdc(`AFEM_OFF_STATUS, 32'h10);
      start(2'd0);
      repeat (4) @(posedge pclk);
      chk(axis_run_q, 4'h0);
    end
    conclude();
  end
endmodule // tb
